// [cpl_host_model.sv]
// Host processor model for the palette's strobed register port.
`timescale 1ns/100ps
module cpl_host_model
(
  input wire logic i_ref_clk,
  input wire logic i_oe_n,
  input wire logic [7:0] i_bus,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_sel_lo,
  output logic o_sel_hi,
  output logic [7:0] o_data
);
  // ****************************************
  // Strobed cycles
  // ****************************************
  // Strobes idle high; select and data idle on a non-matching pattern.
  initial
  begin
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    {o_sel_hi, o_sel_lo} = 2'h0;
    o_data = 8'h5A;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask : tick

  // Select and data are held well past the synchroniser's sampling edge.
  task automatic host_write(input logic [1:0] sel, input logic [7:0] d);
    {o_sel_hi, o_sel_lo} = sel;
    o_data = d;
    o_wr_n = 1'b0;
    tick(6);
    o_wr_n = 1'b1;
    tick(5);
    {o_sel_hi, o_sel_lo} = ~sel;
    o_data = ~d;
    tick(7);
  endtask : host_write

  // Read data is taken at the edge that shows the bus driven.
  task automatic host_read(input logic [1:0] sel, output logic [7:0] d,
                           output bit ok);
    int n;
    {o_sel_hi, o_sel_lo} = sel;
    o_rd_n = 1'b0;
    n = 0;
    while (i_oe_n !== 1'b0 && n < 10)
    begin
      tick(1);
      n++;
    end
    ok = (n < 10);
    d = i_bus;
    tick(2);
    ok = ok && (i_oe_n === 1'b0);
    o_rd_n = 1'b1;
    n = 0;
    while (i_oe_n !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    ok = ok && (n < 10);
    {o_sel_hi, o_sel_lo} = ~sel;
    tick(7);
  endtask : host_read
endmodule : cpl_host_model

// [cpl_palette.sv]
// Color palette: masked pixel lookup, blank pipeline and host port.
//
// Behaviour
// - Table holds 256 entries of 18 bits as red, green, blue fields.
// - Pixel index and blank are sampled on every rising clock edge.
// - Table address is sampled index ANDed with the mask register.
// - Mask updates are taken into the pixel clock domain first.
// - Blank low forces black code on all three outputs.
// - Four register stages from index to outputs; blank matches.
// - Host strobes and accesses are synchronised to the pixel clock.
// - Select inputs are captured at the falling strobe edge.
// - Select 0 write index, 1 color, 2 mask, 3 read index.
// - Write data is captured at the rising write strobe edge.
// - Data bus is driven after read fall, released after rise.
// - Mask and index use 8 bits; colors use six low bits.
// - Mask register reads back its stored value.
// - Host writes index, then red, green, blue to load an entry.
// - Third color write stores entry, then increments index.
// - Writing read index fetches entry into holding and increments.
// - Color reads return red, then green, then blue fields.
// - After blue read, entry at incremented index is fetched.
// - Each table transfer steals exactly one pixel cycle.
// - In a stolen cycle the previous pixel color is repeated.
// - Each 6-bit code selects one of 64 levels; zero is off.
`timescale 1ns/100ps
`include "cpl_regs.svh"
module cpl_palette
  import cpl_pkg::*;
#(
  parameter int ENTRIES = `CPL_ENTRIES
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_pixel_index_in,
  input wire logic i_blank_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_reg_select_lo,
  input wire logic i_reg_select_hi,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_oe_n,
  output logic [5:0] o_red_code,
  output logic [5:0] o_green_code,
  output logic [5:0] o_blue_code
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int EW = 3 * `CPL_COMP_W;

  logic [EW-1:0] table_ff [ENTRIES];
  logic [7:0] pix_ff;
  logic [7:0] addr_ff;
  logic [EW-1:0] look_ff;
  logic [2:0] blank_ff;
  logic steal_ff;
  logic [7:0] pixel_index_mask_ff;
  logic [7:0] mask_vid_ff;
  logic [7:0] table_index_ff;
  logic [EW-1:0] color_value_port_ff;
  logic [EW-1:0] hold_ff;
  cpl_comp_t comp_ff;
  cpl_tbl_t tbl_ff;
  logic [1:0] wsel_ff;
  logic [1:0] rsel_ff;
  logic [7:0] wdata_ff;
  logic rd_active_ff;
  logic [7:0] rdata_ff;
  logic w_fall;
  logic w_rise;
  logic r_fall;
  logic r_rise;
  logic steal;

  initial
  begin
    if (ENTRIES != (1 << `CPL_IDX_W))
      $error("ENTRIES must match the 8-bit index space.");
  end

  // Picks one component field from an entry.
  function automatic logic [5:0] cpl_field(input logic [EW-1:0] e,
                                           input cpl_comp_t c);
    case (c)
      CPL_COMP_RED: cpl_field = e[`CPL_RED_HI:`CPL_RED_LO];
      CPL_COMP_GRN: cpl_field = e[`CPL_GRN_HI:`CPL_GRN_LO];
      default: cpl_field = e[`CPL_BLU_HI:`CPL_BLU_LO];
    endcase
  endfunction : cpl_field

  // ****************************************************************
  // Host strobe synchronisers
  // ****************************************************************
  cpl_strobe_sync u_wr_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_strobe_n(i_wr_n),
    .o_fall(w_fall),
    .o_rise(w_rise)
  );

  cpl_strobe_sync u_rd_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_strobe_n(i_rd_n),
    .o_fall(r_fall),
    .o_rise(r_rise)
  );

  // Select is taken at the falling edge, data at the rising edge.
  // Inputs are asynchronous to the clock, so edges are seen 3 clocks
  // late; the host holds data that long after its strobe rises.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wsel_ff <= `CPL_SEL_WR_INDEX;
      rsel_ff <= `CPL_SEL_WR_INDEX;
      wdata_ff <= 8'h00;
    end
    else
    begin
      if (w_fall)
        wsel_ff <= {i_reg_select_hi, i_reg_select_lo};
      if (r_fall)
        rsel_ff <= {i_reg_select_hi, i_reg_select_lo};
      if (w_rise)
        wdata_ff <= i_host_data_bus;
    end
  end

  // ****************************************************************
  // Host register writes and table sequencing
  // ****************************************************************
  // A host write lands one clock after the rising strobe was seen.
  logic wr_go_ff;
  logic rd_done_ff;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wr_go_ff <= 1'b0;
      rd_done_ff <= 1'b0;
    end
    else
    begin
      wr_go_ff <= w_rise;
      rd_done_ff <= r_rise && rsel_ff == `CPL_SEL_COLOR;
    end
  end

  // Index, mask, component counter and table state.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      table_index_ff <= 8'h00;
      pixel_index_mask_ff <= `CPL_MASK_INIT;
      color_value_port_ff <= '0;
      comp_ff <= CPL_COMP_RED;
      tbl_ff <= CPL_TBL_IDLE;
    end
    else
    begin
      tbl_ff <= CPL_TBL_IDLE;
      if (tbl_ff != CPL_TBL_IDLE)
        table_index_ff <= table_index_ff + 8'h01;
      if (wr_go_ff)
      begin
        case (wsel_ff)
          `CPL_SEL_WR_INDEX:
          begin
            table_index_ff <= wdata_ff;
            comp_ff <= CPL_COMP_RED;
          end
          `CPL_SEL_RD_INDEX:
          begin
            table_index_ff <= wdata_ff;
            comp_ff <= CPL_COMP_RED;
            tbl_ff <= CPL_TBL_FETCH;
          end
          `CPL_SEL_MASK: pixel_index_mask_ff <= wdata_ff;
          `CPL_SEL_COLOR:
          begin
            case (comp_ff)
              CPL_COMP_RED:
              begin
                color_value_port_ff[`CPL_RED_HI:`CPL_RED_LO] <=
                  wdata_ff[5:0];
                comp_ff <= CPL_COMP_GRN;
              end
              CPL_COMP_GRN:
              begin
                color_value_port_ff[`CPL_GRN_HI:`CPL_GRN_LO] <=
                  wdata_ff[5:0];
                comp_ff <= CPL_COMP_BLU;
              end
              default:
              begin
                color_value_port_ff[`CPL_BLU_HI:`CPL_BLU_LO] <=
                  wdata_ff[5:0];
                comp_ff <= CPL_COMP_RED;
                tbl_ff <= CPL_TBL_WRITE;
              end
            endcase
          end
          default: ;
        endcase
      end
      else if (rd_done_ff)
      begin
        // Color reads step the same counter; blue triggers a refetch.
        case (comp_ff)
          CPL_COMP_RED: comp_ff <= CPL_COMP_GRN;
          CPL_COMP_GRN: comp_ff <= CPL_COMP_BLU;
          default:
          begin
            comp_ff <= CPL_COMP_RED;
            tbl_ff <= CPL_TBL_FETCH;
          end
        endcase
      end
    end
  end

  // Table port: one write or one fetch per stolen cycle.
  assign steal = tbl_ff != CPL_TBL_IDLE;

  always_ff @(posedge i_ref_clk)
  begin
    if (tbl_ff == CPL_TBL_WRITE)
      table_ff[table_index_ff] <= color_value_port_ff;
  end

  // Holding register is loaded in the stolen cycle.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      hold_ff <= '0;
    else if (tbl_ff == CPL_TBL_FETCH)
      hold_ff <= table_ff[table_index_ff];
  end

  // ****************************************************************
  // Host read data and bus drive
  // ****************************************************************
  // No table data is ever presented unsynchronised; the read value is
  // frozen when the strobe fall is seen.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      rd_active_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      if (r_fall)
        rd_active_ff <= 1'b1;
      else if (r_rise)
        rd_active_ff <= 1'b0;
      if (r_fall)
      begin
        case ({i_reg_select_hi, i_reg_select_lo})
          `CPL_SEL_MASK: rdata_ff <= pixel_index_mask_ff;
          `CPL_SEL_COLOR:
            rdata_ff <= {2'b00, cpl_field(hold_ff, comp_ff)};
          default: rdata_ff <= table_index_ff;
        endcase
      end
    end
  end

  assign o_host_data_bus = rdata_ff;
  assign o_host_data_oe_n = ~rd_active_ff;

  // ****************************************************************
  // Video pipeline
  // ****************************************************************
  // Mask is re-registered in the pixel path so a write never splits
  // an address mid-cycle.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      mask_vid_ff <= `CPL_MASK_INIT;
    else
      mask_vid_ff <= pixel_index_mask_ff;
  end

  // Stage 1 sample, stage 2 address, stage 3 lookup, stage 4 output.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      pix_ff <= 8'h00;
      addr_ff <= 8'h00;
      look_ff <= '0;
      blank_ff <= 3'h0;
      steal_ff <= 1'b0;
      o_red_code <= `CPL_BLACK_CODE;
      o_green_code <= `CPL_BLACK_CODE;
      o_blue_code <= `CPL_BLACK_CODE;
    end
    else
    begin
      pix_ff <= i_pixel_index_in;
      blank_ff <= {blank_ff[1:0], i_blank_n};
      addr_ff <= pix_ff & mask_vid_ff;
      steal_ff <= steal;
      if (!steal)
        look_ff <= table_ff[addr_ff];
      if (!blank_ff[2])
      begin
        o_red_code <= `CPL_BLACK_CODE;
        o_green_code <= `CPL_BLACK_CODE;
        o_blue_code <= `CPL_BLACK_CODE;
      end
      else if (!steal_ff)
      begin
        o_red_code <= look_ff[`CPL_RED_HI:`CPL_RED_LO];
        o_green_code <= look_ff[`CPL_GRN_HI:`CPL_GRN_LO];
        o_blue_code <= look_ff[`CPL_BLU_HI:`CPL_BLU_LO];
      end
      // A stolen slot leaves the output holding the prior pixel.
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_blank_seen;
    !i_blank_n;
  endsequence

  a_blank_black: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) s_blank_seen ##3 1'b1 |=>
    o_red_code == `CPL_BLACK_CODE && o_green_code == `CPL_BLACK_CODE &&
    o_blue_code == `CPL_BLACK_CODE)
    else $error("Blank did not force black after three clocks.");

  a_mask_addr: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) 1'b1 |=> addr_ff ==
    ($past(i_pixel_index_in, 2) & $past(pixel_index_mask_ff, 2)))
    else $error("Address is not index ANDed with mask.");

  a_mask_sync: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) $changed(pixel_index_mask_ff) |=>
    mask_vid_ff == $past(pixel_index_mask_ff))
    else $error("Mask did not reach the pixel path.");

  a_steal_hold: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) steal_ff && blank_ff[2] |=>
    $stable(o_red_code) && $stable(o_green_code))
    else $error("Output changed during a stolen cycle.");

  a_steal_once: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) steal |=> !steal)
    else $error("Table transfer stole more than one cycle.");

  a_write_incr: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) tbl_ff == CPL_TBL_WRITE && !wr_go_ff |=>
    table_index_ff == $past(table_index_ff) + 8'h01)
    else $error("Index did not advance after table write.");

  a_bus_drive: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) r_fall |=> !o_host_data_oe_n)
    else $error("Bus not driven after read strobe fell.");

  a_bus_release: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) r_rise |=> o_host_data_oe_n)
    else $error("Bus not released after read strobe rose.");

  a_index_seq: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) wr_go_ff && wsel_ff[0] == wsel_ff[1] |=>
    comp_ff == CPL_COMP_RED)
    else $error("Index write did not restart at red.");
endmodule : cpl_palette

// [cpl_pkg.sv]
// Types shared by the color palette files.
package cpl_pkg;
  typedef enum logic [1:0]
  {
    CPL_COMP_RED = 2'h0,
    CPL_COMP_GRN = 2'h1,
    CPL_COMP_BLU = 2'h2
  } cpl_comp_t;
  typedef enum logic [1:0]
  {
    CPL_TBL_IDLE = 2'h0,
    CPL_TBL_WRITE = 2'h1,
    CPL_TBL_FETCH = 2'h2
  } cpl_tbl_t;
endpackage : cpl_pkg

// [cpl_regs.svh]
// Register map, field layout and timing constants of the color palette.
`ifndef CPL_REGS_SVH
`define CPL_REGS_SVH
`define CPL_SEL_WR_INDEX 2'h0
`define CPL_SEL_COLOR 2'h1
`define CPL_SEL_MASK 2'h2
`define CPL_SEL_RD_INDEX 2'h3
`define CPL_COMP_W 6
`define CPL_IDX_W 8
`define CPL_ENTRIES 256
`define CPL_BLACK_CODE 6'h00
`define CPL_MASK_INIT 8'hFF
`define CPL_RED_HI 17
`define CPL_RED_LO 12
`define CPL_GRN_HI 11
`define CPL_GRN_LO 6
`define CPL_BLU_HI 5
`define CPL_BLU_LO 0
`define CPL_PIPE_DELAY 3
`define CPL_RD_WAIT_CYC 6
`endif

// [cpl_strobe_sync.sv]
// Strobe synchroniser with edge detection for one active-low host strobe.
`timescale 1ns/100ps
module cpl_strobe_sync
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_strobe_n,
  output logic o_fall,
  output logic o_rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Two flops for the level, a third only for the edge compare.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= i_strobe_n;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge pulses last one clock each.
  assign o_fall = prev_ff & ~sync_ff;
  assign o_rise = ~prev_ff & sync_ff;
endmodule : cpl_strobe_sync

// [test_color_palette_lookup.sv]
// Self-checking bench for the color palette lookup block.
`timescale 1ns/100ps
`include "cpl_regs.svh"
module test_color_palette_lookup;
  typedef struct {logic [7:0] mask, pix; logic bn; logic [7:0] ix;} cpl_row_t;
  logic i_ref_clk, i_sys_rst, blank_n, rd_n, wr_n, sel_lo, sel_hi, oe_n;
  logic [7:0] pix, hdata, ddata, bus, rd, cur_mask;
  logic [5:0] red, grn, blu;
  logic [17:0] prev;
  logic alt_on = 1'b0;
  logic watch = 1'b0;
  int fail_count = 0;
  int n_checks = 0;
  int reps;
  bit ok;
  cpl_row_t rows [6] = '{'{8'hFF, 8'hFF, 1'b1, 8'hFF},
    '{8'hFF, 8'h01, 1'b1, 8'h01}, '{8'hFF, 8'h02, 1'b0, 8'h00},
    '{8'h02, 8'h03, 1'b1, 8'h02}, '{8'h00, 8'h02, 1'b1, 8'h00},
    '{8'hA5, 8'h5A, 1'b1, 8'h00}};

  // The bus carries the device's drive only while it enables it.
  assign bus = (oe_n === 1'b0) ? ddata : hdata;

  cpl_palette dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_pixel_index_in(pix), .i_blank_n(blank_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_reg_select_lo(sel_lo), .i_reg_select_hi(sel_hi),
    .i_host_data_bus(bus), .o_host_data_bus(ddata),
    .o_host_data_oe_n(oe_n), .o_red_code(red), .o_green_code(grn),
    .o_blue_code(blu));
  cpl_host_model host_u (.i_ref_clk(i_ref_clk), .i_oe_n(oe_n), .i_bus(bus),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel_lo(sel_lo), .o_sel_hi(sel_hi),
    .o_data(hdata));

  // ****************************************
  // Helpers
  // ****************************************
  // Pixel clock generator.
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // Counts repeated colors, then steps the pixel through three entries.
  // A cycle of three keeps the slot after a repeat different from it;
  // with two entries that slot would match and count a second time.
  always @(posedge i_ref_clk)
  begin
    #1;
    if (watch && {red, grn, blu} === prev) reps++;
    prev = {red, grn, blu};
    #1;
    if (alt_on)
      pix = (pix == 8'hFF) ? 8'h00 : ((pix == 8'h00) ? 8'h01 : 8'hFF);
  end

  function automatic logic [17:0] ent(input logic [7:0] i);
    return {i[5:0] ^ 6'h15, i[5:0] + 6'h07, ~i[5:0]};
  endfunction : ent

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask : tick

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // A hung read is a mismatch and ends the run at once.
  task automatic rdck(input logic [1:0] s, input logic [7:0] e,
                      input logic [7:0] m);
    host_u.host_read(s, rd, ok);
    if (!ok)
    begin
      fail_count++;
      $display("BAD t=%0t read timed out", $time);
      tally_and_finish();
    end
    else
      chk({10'h000, rd & m}, {10'h000, e & m});
  endtask : rdck

  // Upper data bits are set on purpose; only six low bits may land.
  task automatic wr_ent(input logic [7:0] k);
    logic [17:0] e;
    e = ent(k);
    host_u.host_write(`CPL_SEL_COLOR, {2'h3, e[17:12]});
    host_u.host_write(`CPL_SEL_COLOR, {2'h3, e[11:6]});
    host_u.host_write(`CPL_SEL_COLOR, {2'h3, e[5:0]});
  endtask : wr_ent

  task automatic rd_ent(input logic [7:0] k);
    logic [17:0] e;
    e = ent(k);
    rdck(`CPL_SEL_COLOR, {2'h0, e[17:12]}, 8'h3F);
    rdck(`CPL_SEL_COLOR, {2'h0, e[11:6]}, 8'h3F);
    rdck(`CPL_SEL_COLOR, {2'h0, e[5:0]}, 8'h3F);
  endtask : rd_ent

  // One pixel shown, then blank: the entry must land exactly 4 edges on.
  task automatic vid(input logic [7:0] p, input logic b,
                     input logic [17:0] e);
    pix = p;
    blank_n = b;
    tick(1);
    blank_n = 1'b0;
    tick(3);
    chk({red, grn, blu}, e);
    tick(1);
    chk({red, grn, blu}, {3{`CPL_BLACK_CODE}});
  endtask : vid

  // ****************************************
  // Main sequence
  // ****************************************
  // Load across the index wrap, read back, steal cycles, then video rows.
  initial
  begin
    i_sys_rst = 1'b1;
    pix = 8'h00;
    blank_n = 1'b0;
    tick(10);
    i_sys_rst = 1'b0;
    chk({red, grn, blu}, 18'h0);
    chk({17'h0, oe_n}, 18'h1);
    rdck(`CPL_SEL_MASK, `CPL_MASK_INIT, 8'hFF);
    host_u.host_write(`CPL_SEL_WR_INDEX, 8'hFF);
    host_u.host_write(`CPL_SEL_COLOR, 8'h3F);
    host_u.host_write(`CPL_SEL_WR_INDEX, 8'hFF);
    for (int i = 0; i < 4; i++) wr_ent(8'(255 + i));
    host_u.host_write(`CPL_SEL_RD_INDEX, 8'hFF);
    rdck(`CPL_SEL_COLOR, {2'h0, 6'h2A}, 8'h3F);
    host_u.host_write(`CPL_SEL_RD_INDEX, 8'hFF);
    for (int i = 0; i < 4; i++) rd_ent(8'(255 + i));
    blank_n = 1'b1;
    alt_on = 1'b1;
    tick(8);
    watch = 1'b1;
    tick(2);
    reps = 0;
    wr_ent(8'h40);
    chk(18'(reps), 18'h1);
    reps = 0;
    host_u.host_write(`CPL_SEL_RD_INDEX, 8'hFF);
    rd_ent(8'hFF);
    chk(18'(reps), 18'h2);
    alt_on = 1'b0;
    watch = 1'b0;
    blank_n = 1'b0;
    cur_mask = 8'hFF;
    foreach (rows[i])
    begin
      cpl_row_t r;
      r = rows[i];
      if (r.mask !== cur_mask)
      begin
        host_u.host_write(`CPL_SEL_MASK, r.mask);
        cur_mask = r.mask;
      end
      vid(r.pix, r.bn, r.bn ? ent(r.ix) : 18'h0);
    end
    rdck(`CPL_SEL_MASK, 8'hA5, 8'hFF);
    tally_and_finish();
  end
endmodule : test_color_palette_lookup
